// ---- design/scc_defs.vh ----
// Notes on behaviour
// - clock-mode bit picks transmit-end timing and, with clock enables, the clock pin state.
// - clock-output enable 0 drives no card clock; 1 outputs the card clock.
// - channel acts as a card interface only while card mode enable is 1.
// - direct: 1 is released high, LSB first, even parity; 0x3B parity 1.
// - inverse: 1 is low, MSB first; 0x3F gets parity 0, sent high.
// - data inversion touches the eight data bits only, never parity, both directions.
// - card mode clocks only from the internal bit-rate generator.
// - bit rate is clock / (1488 * 2^(2n-1) * (N+1)), N 0..255.
// - prescale select bits give n directly in binary, 0 to 3.
// - card clock on the clock pin runs at 372 times the bit rate.
// - clock-mode 1, output enable 0: pin drives level of clock level select.
// - clock pin follows an output enable write at once; level select 0 if clock-mode 0.
// - restarting the card clock never makes a shortened pulse; stopping it cuts the pin over at once and can shorten one.
// - frame is start, eight data, parity; at least 2 etu guard before next.
// - transmit-end sets 2.5 etu after a byte (clock-mode 0) or 1.0 etu (1).
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// register addresses
`define SCC_ADDR_SMR 32'hFFFFFE80
`define SCC_ADDR_BRR 32'hFFFFFE82
`define SCC_ADDR_SCR 32'hFFFFFE84
`define SCC_ADDR_TDR 32'hFFFFFE86
`define SCC_ADDR_SSR 32'hFFFFFE88
`define SCC_ADDR_RDR 32'hFFFFFE8A
`define SCC_ADDR_CMR 32'hFFFFFE8C

// mode register fields
`define SCC_SMR_CA 7
`define SCC_SMR_ODD 4
`define SCC_SMR_CKS_HI 1
`define SCC_SMR_CKS_LO 0
// control register fields
`define SCC_SCR_TE 5
`define SCC_SCR_RE 4
`define SCC_SCR_CLOCK_LEVEL_SELECT 1
`define SCC_SCR_CLOCK_OUTPUT_ENABLE 0
// card mode register fields
`define SCC_CMR_BIT_ORDER_SELECT 3
`define SCC_CMR_DATA_INVERT 2
`define SCC_CMR_CARD_MODE_ENABLE 0
// status register fields
`define SCC_SSR_TX_BUFFER_EMPTY 7
`define SCC_SSR_RX_BUFFER_FULL 6
`define SCC_SSR_OVERRUN_FLAG 5
`define SCC_SSR_ERS 4
`define SCC_SSR_PER 3
`define SCC_SSR_TRANSMIT_END_FLAG 2

// reset value and card mode register write mask
`define SCC_RST_BYTE 8'h00
`define SCC_RST_CMR_MASK 8'h0D

// timing, counted in half etu (one etu is 372 base ticks, two half ticks each)
`define SCC_BASE_PER_ETU 372
`define SCC_HALF_ETU_TICKS 9'd372
`define SCC_H_FRAME_END 5'd20
`define SCC_H_ERR_SAMPLE 5'd21
`define SCC_H_TRANSMIT_END_FLAG_CA1 5'd22
`define SCC_H_TRANSMIT_END_FLAG_CA0 5'd25
`define SCC_H_GUARD_END 5'd25
`define SCC_H_RX_LAST 5'd19

`endif

// ---- design/scc_brg.v ----
`timescale 1ns/100ps
`default_nettype none

module scc_brg (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// settings
	input wire [7:0] div,
	input wire [1:0] prescale,
	input wire restart,
	// outputs
	output reg half_tick_q,
	output reg card_clk_q
);

// one base tick is 2 * 4^n * (N+1) mclk; a half tick flips the card clock
wire [14:0] base_cnt;
wire [14:0] term_cnt;
reg [14:0] cnt_q;

assign base_cnt = {7'h00, div} + 15'h0001;
assign term_cnt = (base_cnt << {prescale, 1'b0}) - 15'h0001;

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		cnt_q <= 15'h0000;
		half_tick_q <= 1'b0;
		card_clk_q <= 1'b0;
	end
	else if (restart)
	begin
		// start from a full low phase so the first pulse is whole
		cnt_q <= 15'h0000;
		half_tick_q <= 1'b0;
		card_clk_q <= 1'b0;
	end
	else if (cnt_q >= term_cnt)
	begin
		cnt_q <= 15'h0000;
		half_tick_q <= 1'b1;
		card_clk_q <= ~card_clk_q;
	end
	else
	begin
		cnt_q <= cnt_q + 15'h0001;
		half_tick_q <= 1'b0;
	end
end

endmodule

`default_nettype wire

// ---- design/scc_card_if.v ----
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"

module scc_card_if (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// register port
	input wire [31:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// card data line, open drain
	input wire sd_i,
	output wire sd_o,
	output wire sd_oe,
	// card clock pin
	output wire sck_o,
	output wire sck_oe,
	output wire sck_port_sel
);

////////////////////////////////////////////////////////////////////////
// registers

localparam TX_IDLE = 1'b0;
localparam TX_RUN = 1'b1;
localparam RX_IDLE = 1'b0;
localparam RX_RUN = 1'b1;

reg [7:0] smr_q;
reg [7:0] brr_q;
reg [7:0] scr_q;
reg [7:0] tdr_q;
reg [7:0] rdr_q;
reg [7:0] cmr_q;
reg tx_buffer_empty_q;
reg rx_buffer_full_q;
reg overrun_flag_q;
reg ers_q;
reg per_q;
reg transmit_end_flag_q;

wire wr_smr = reg_wr && (reg_addr == `SCC_ADDR_SMR);
wire wr_brr = reg_wr && (reg_addr == `SCC_ADDR_BRR);
wire wr_scr = reg_wr && (reg_addr == `SCC_ADDR_SCR);
wire wr_tdr = reg_wr && (reg_addr == `SCC_ADDR_TDR);
wire wr_ssr = reg_wr && (reg_addr == `SCC_ADDR_SSR);
wire wr_cmr = reg_wr && (reg_addr == `SCC_ADDR_CMR);

wire card_mode = cmr_q[`SCC_CMR_CARD_MODE_ENABLE];
wire ca_mode = smr_q[`SCC_SMR_CA];
wire odd_par = smr_q[`SCC_SMR_ODD];
wire msb_first = cmr_q[`SCC_CMR_BIT_ORDER_SELECT];
wire data_inv = cmr_q[`SCC_CMR_DATA_INVERT];
wire tx_en = scr_q[`SCC_SCR_TE] && card_mode;
wire rx_en = scr_q[`SCC_SCR_RE] && card_mode;

function [7:0] rev8;
	input [7:0] v;
	integer i;
	begin
		for (i = 0; i < 8; i = i + 1)
			rev8[i] = v[7 - i];
	end
endfunction

////////////////////////////////////////////////////////////////////////
// bit-rate generator, the only clock source in card mode

wire half_tick;
wire card_clk;
wire clk_restart = wr_scr && reg_wdata[`SCC_SCR_CLOCK_OUTPUT_ENABLE] &&
	!scr_q[`SCC_SCR_CLOCK_OUTPUT_ENABLE];

scc_brg u_brg (
	.mclk(mclk),
	.rst_n(rst_n),
	.div(brr_q),
	.prescale(smr_q[`SCC_SMR_CKS_HI:`SCC_SMR_CKS_LO]),
	.restart(clk_restart),
	.half_tick_q(half_tick),
	.card_clk_q(card_clk)
);

////////////////////////////////////////////////////////////////////////
// data line input, two stages before any logic

reg sd_s1_q;
reg sd_s2_q;
reg sd_prev_q;

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		sd_s1_q <= 1'b1;
		sd_s2_q <= 1'b1;
		sd_prev_q <= 1'b1;
	end
	else
	begin
		sd_s1_q <= sd_i;
		sd_s2_q <= sd_s1_q;
		sd_prev_q <= sd_s2_q;
	end
end

////////////////////////////////////////////////////////////////////////
// transmitter

reg tx_state_q;
reg [8:0] tx_sub_q;
reg [4:0] tx_h_q;
reg [9:0] tx_frame_q;
reg sd_oe_q;

wire [7:0] tx_line = data_inv ? ~tdr_q : tdr_q;
wire [7:0] tx_order = msb_first ? rev8(tx_line) : tx_line;
wire tx_par = (^tx_line) ^ odd_par;
wire tx_load = (tx_state_q == TX_IDLE) && tx_en && !tx_buffer_empty_q;
wire tx_half_etu = half_tick && (tx_sub_q == `SCC_HALF_ETU_TICKS - 9'd1);
wire tx_at_h = (tx_state_q == TX_RUN) && half_tick && (tx_sub_q == 9'd0);
wire [4:0] transmit_end_flag_h = ca_mode ? `SCC_H_TRANSMIT_END_FLAG_CA1 : `SCC_H_TRANSMIT_END_FLAG_CA0;
wire transmit_end_flag_evt = tx_at_h && (tx_h_q == transmit_end_flag_h) && tx_buffer_empty_q && !ers_q;
wire ers_evt = tx_at_h && (tx_h_q == `SCC_H_ERR_SAMPLE) && !sd_s2_q;

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		tx_state_q <= TX_IDLE;
		tx_sub_q <= 9'd0;
		tx_h_q <= 5'd0;
		tx_frame_q <= 10'h3FF;
		sd_oe_q <= 1'b0;
	end
	else
	begin
		case (tx_state_q)
		TX_IDLE:
		begin
			sd_oe_q <= 1'b0;
			if (tx_load)
			begin
				// start bit low, then data, then parity
				tx_frame_q <= {tx_par, tx_order, 1'b0};
				tx_sub_q <= 9'd0;
				tx_h_q <= 5'd0;
				tx_state_q <= TX_RUN;
			end
		end
		TX_RUN:
		begin
			if (!tx_en)
			begin
				tx_state_q <= TX_IDLE;
				sd_oe_q <= 1'b0;
			end
			else
			begin
				if (half_tick)
				begin
					if (tx_half_etu)
						tx_sub_q <= 9'd0;
					else
						tx_sub_q <= tx_sub_q + 9'd1;
				end
				if (tx_half_etu)
				begin
					if (tx_h_q == `SCC_H_GUARD_END)
						tx_state_q <= TX_IDLE;
					else
						tx_h_q <= tx_h_q + 5'd1;
				end
				// line low only for a zero bit, released otherwise
				if (tx_h_q < `SCC_H_FRAME_END)
					sd_oe_q <= ~tx_frame_q[tx_h_q[4:1]];
				else
					sd_oe_q <= 1'b0;
			end
		end
		default:
			tx_state_q <= TX_IDLE;
		endcase
	end
end

assign sd_o = 1'b0;
assign sd_oe = sd_oe_q;

////////////////////////////////////////////////////////////////////////
// receiver

reg rx_state_q;
reg [8:0] rx_sub_q;
reg [4:0] rx_h_q;
reg [8:0] rx_sr_q;

wire rx_start = (rx_state_q == RX_IDLE) && rx_en &&
	(tx_state_q == TX_IDLE) && sd_prev_q && !sd_s2_q;
wire rx_half_etu = half_tick && (rx_sub_q == `SCC_HALF_ETU_TICKS - 9'd1);
wire rx_sample = (rx_state_q == RX_RUN) && half_tick &&
	(rx_sub_q == 9'd0) && rx_h_q[0];
wire rx_done = rx_sample && (rx_h_q == `SCC_H_RX_LAST);
wire [8:0] rx_full = {sd_s2_q, rx_sr_q[8:1]};
wire [7:0] rx_order = msb_first ? rev8(rx_full[7:0]) : rx_full[7:0];
wire [7:0] rx_data = data_inv ? ~rx_order : rx_order;
wire rx_bad = (^rx_full[7:0]) ^ rx_full[8] ^ odd_par;
wire per_evt = rx_done && rx_bad;
wire rx_buffer_full_evt = rx_done && !rx_bad && !rx_buffer_full_q;
wire overrun_flag_evt = rx_done && !rx_bad && rx_buffer_full_q;

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		rx_state_q <= RX_IDLE;
		rx_sub_q <= 9'd0;
		rx_h_q <= 5'd0;
		rx_sr_q <= 9'h000;
	end
	else
	begin
		case (rx_state_q)
		RX_IDLE:
		begin
			if (rx_start)
			begin
				rx_sub_q <= 9'd0;
				rx_h_q <= 5'd0;
				rx_state_q <= RX_RUN;
			end
		end
		RX_RUN:
		begin
			if (half_tick)
			begin
				if (rx_half_etu)
					rx_sub_q <= 9'd0;
				else
					rx_sub_q <= rx_sub_q + 9'd1;
			end
			if (rx_half_etu)
				rx_h_q <= rx_h_q + 5'd1;
			if (!rx_en)
				rx_state_q <= RX_IDLE;
			else if (rx_sample && (rx_h_q == 5'd1))
			begin
				// a start bit that is high again was a glitch
				if (sd_s2_q)
					rx_state_q <= RX_IDLE;
			end
			else if (rx_sample)
			begin
				rx_sr_q <= rx_full;
				if (rx_done)
					rx_state_q <= RX_IDLE;
			end
		end
		default:
			rx_state_q <= RX_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// register file; a hardware set wins over a clearing write

wire clr_tx_buffer_empty = wr_ssr && !reg_wdata[`SCC_SSR_TX_BUFFER_EMPTY];

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		smr_q <= `SCC_RST_BYTE;
		brr_q <= `SCC_RST_BYTE;
		scr_q <= `SCC_RST_BYTE;
		tdr_q <= `SCC_RST_BYTE;
		rdr_q <= `SCC_RST_BYTE;
		cmr_q <= `SCC_RST_BYTE;
		tx_buffer_empty_q <= 1'b1;
		rx_buffer_full_q <= 1'b0;
		overrun_flag_q <= 1'b0;
		ers_q <= 1'b0;
		per_q <= 1'b0;
		transmit_end_flag_q <= 1'b1;
	end
	else
	begin
		if (wr_smr)
			smr_q <= reg_wdata;
		if (wr_brr)
			brr_q <= reg_wdata;
		if (wr_scr)
			scr_q <= reg_wdata;
		if (wr_tdr)
			tdr_q <= reg_wdata;
		if (wr_cmr)
			cmr_q <= reg_wdata & `SCC_RST_CMR_MASK;
		if (rx_buffer_full_evt)
			rdr_q <= rx_data;
		if (tx_load)
			tx_buffer_empty_q <= 1'b1;
		else if (clr_tx_buffer_empty)
			tx_buffer_empty_q <= 1'b0;
		if (rx_buffer_full_evt)
			rx_buffer_full_q <= 1'b1;
		else if (wr_ssr && !reg_wdata[`SCC_SSR_RX_BUFFER_FULL])
			rx_buffer_full_q <= 1'b0;
		if (overrun_flag_evt)
			overrun_flag_q <= 1'b1;
		else if (wr_ssr && !reg_wdata[`SCC_SSR_OVERRUN_FLAG])
			overrun_flag_q <= 1'b0;
		if (ers_evt)
			ers_q <= 1'b1;
		else if (wr_ssr && !reg_wdata[`SCC_SSR_ERS])
			ers_q <= 1'b0;
		if (per_evt)
			per_q <= 1'b1;
		else if (wr_ssr && !reg_wdata[`SCC_SSR_PER])
			per_q <= 1'b0;
		if (transmit_end_flag_evt || (!scr_q[`SCC_SCR_TE] && !ers_q))
			transmit_end_flag_q <= 1'b1;
		else if (clr_tx_buffer_empty || tx_load)
			transmit_end_flag_q <= 1'b0;
	end
end

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
		reg_rdata <= 8'h00;
	else if (!reg_rd)
		reg_rdata <= 8'h00;
	else if (reg_addr == `SCC_ADDR_SMR)
		reg_rdata <= smr_q;
	else if (reg_addr == `SCC_ADDR_BRR)
		reg_rdata <= brr_q;
	else if (reg_addr == `SCC_ADDR_SCR)
		reg_rdata <= scr_q;
	else if (reg_addr == `SCC_ADDR_TDR)
		reg_rdata <= tdr_q;
	else if (reg_addr == `SCC_ADDR_SSR)
		reg_rdata <= {tx_buffer_empty_q, rx_buffer_full_q, overrun_flag_q, ers_q, per_q, transmit_end_flag_q, 2'b00};
	else if (reg_addr == `SCC_ADDR_RDR)
		reg_rdata <= rdr_q;
	else if (reg_addr == `SCC_ADDR_CMR)
		reg_rdata <= cmr_q;
	else
		reg_rdata <= 8'h00;
end

////////////////////////////////////////////////////////////////////////
// clock pin selection

reg sck_o_q;
reg sck_oe_q;
reg sck_port_q;

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		sck_o_q <= 1'b0;
		sck_oe_q <= 1'b0;
		sck_port_q <= 1'b1;
	end
	else if (!card_mode)
	begin
		sck_o_q <= 1'b0;
		sck_oe_q <= 1'b0;
		sck_port_q <= 1'b1;
	end
	else if (scr_q[`SCC_SCR_CLOCK_OUTPUT_ENABLE])
	begin
		sck_o_q <= card_clk;
		sck_oe_q <= 1'b1;
		sck_port_q <= 1'b0;
	end
	else if (!ca_mode)
	begin
		sck_o_q <= 1'b0;
		sck_oe_q <= 1'b0;
		sck_port_q <= 1'b1;
	end
	else
	begin
		sck_o_q <= scr_q[`SCC_SCR_CLOCK_LEVEL_SELECT];
		sck_oe_q <= 1'b1;
		sck_port_q <= 1'b0;
	end
end

assign sck_o = sck_o_q;
assign sck_oe = sck_oe_q;
assign sck_port_sel = sck_port_q;

endmodule

`default_nettype wire

// ---- dv/scc_chk_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"
module scc_chk (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// register port
	input wire [31:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// pins
	input wire sd_i,
	input wire sd_o,
	input wire sd_oe,
	input wire sck_o,
	input wire sck_oe,
	input wire sck_port_sel
);
	reg [7:0] smr_q, brr_q, scr_q, cmr_q;
	reg [15:0] cnt_q;
	reg prev_q, ok_q;
	wire chg = sck_o != prev_q;
	wire run = cmr_q[0] & scr_q[0];
	wire hold = cmr_q[0] & smr_q[7] & ~scr_q[0];
	wire port = cmr_q[0] & ~smr_q[7] & ~scr_q[0];
	wire wr_rate = reg_wr & (reg_addr == `SCC_ADDR_SMR
		| reg_addr == `SCC_ADDR_BRR);
	wire [15:0] lim = (({8'h00, brr_q} + 16'h1) << {smr_q[1:0], 1'b0}) - 16'h1;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// shadow registers; ok_q skips the first half period after a restart
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{smr_q, brr_q, scr_q, cmr_q} <= 32'h0;
			{cnt_q, prev_q, ok_q} <= 18'h0;
		end
		else
		begin
			if (reg_wr && reg_addr == `SCC_ADDR_SMR)
				smr_q <= reg_wdata;
			if (reg_wr && reg_addr == `SCC_ADDR_BRR)
				brr_q <= reg_wdata;
			if (reg_wr && reg_addr == `SCC_ADDR_SCR)
				scr_q <= reg_wdata;
			if (reg_wr && reg_addr == `SCC_ADDR_CMR)
				cmr_q <= reg_wdata & `SCC_RST_CMR_MASK;
			prev_q <= sck_o;
			cnt_q <= chg ? 16'h0 : cnt_q + 16'h1;
			ok_q <= run & ~wr_rate & (ok_q | chg);
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_sd_open: assert property (sd_o == 1'b0)
		else $error("data pin driven high");
	a_port_idle: assert property (sck_port_sel |-> !sck_oe)
		else $error("port pin also driven");
	a_mode_off: assert property (!cmr_q[0] |=> sck_port_sel && !sck_oe)
		else $error("clock pin used outside card mode");
	a_clk_on: assert property (run |=> sck_oe && !sck_port_sel)
		else $error("card clock not driven");
	a_hold: assert property (hold |=> sck_oe & sck_o == $past(scr_q[1]))
		else $error("static clock level wrong");
	a_port: assert property (port |=> sck_port_sel)
		else $error("clock pin not handed to port");
	a_half: assert property (chg && ok_q |-> cnt_q == lim)
		else $error("card clock half period wrong");
	a_tx_mode: assert property (sd_oe |-> $past(scr_q[5] & cmr_q[0]))
		else $error("data line pulled while not sending");
	a_start_len: assert property ($rose(sd_oe) |-> sd_oe [*8])
		else $error("start bit too short");
	c_tx: cover property ($rose(sd_oe));
	c_half: cover property (chg && ok_q);
	c_hold_hi: cover property (hold && scr_q[1]);
endmodule
bind scc_card_if scc_chk i_chk (.mclk(mclk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sd_i(sd_i), .sd_o(sd_o),
	.sd_oe(sd_oe), .sck_o(sck_o), .sck_oe(sck_oe),
	.sck_port_sel(sck_port_sel));
`default_nettype wire

// ---- dv/scc_card_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module scc_card_model #(
	parameter ETU = 744
) (
	// line and clock
	input wire mclk,
	input wire dut_oe,
	output wire line
);
	reg pull_q = 1'b0;
	// pull-up: the line is high unless a party pulls it low
	assign line = ~(dut_oe | pull_q);
	task send(input logic [9:0] bits);
		integer i;
		for (i = 0; i < 10; i++)
		begin
			@(posedge mclk);
			pull_q <= ~bits[i];
			repeat (ETU - 1) @(posedge mclk);
		end
		@(posedge mclk);
		pull_q <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- dv/test_scc_card_if.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"
module test_scc_card_if;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] reg_addr = 32'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_q = 1'b0;
	logic [15:0] q[$];
	logic [9:0] bv;
	logic [7:0] d;
	integer fails = 0, compares = 0, seed = 44575, cyc, h, i, k, n;
	wire [7:0] reg_rdata;
	wire sd_o, sd_oe, sck_o, sck_oe, sck_port_sel, line;
	always #10 mclk = ~mclk;
	scc_card_if i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sd_i(line), .sd_o(sd_o), .sd_oe(sd_oe),
		.sck_o(sck_o), .sck_oe(sck_oe), .sck_port_sel(sck_port_sel));
	scc_card_model i_card (.mclk(mclk), .dut_oe(sd_oe), .line(line));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [31:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q.push_back({8'h00, v});
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask
	// waits for a pin level, counting edges; a hang ends the run
	task till(input integer s, input logic v);
		cyc = 0;
		while (((s == 0) ? sck_o : sd_oe) !== v)
		begin
			@(posedge mclk);
			cyc++;
			if (cyc > 3000)
			begin
				fails++;
				test_done;
			end
		end
	endtask
	// line levels of a frame: start, eight data, parity
	function automatic logic [9:0] expl(input logic [7:0] v, input logic c);
		logic [7:0] x;
		x = v ^ {8{c}};
		if (c)
			x = {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
		return {^x ^ c, x, 1'b0};
	endfunction
	always @(posedge mclk)
	begin
		if (rd_q)
			chk({8'h00, reg_rdata}, q.pop_front());
		rd_q <= reg_rd;
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`SCC_ADDR_SSR, 8'h84);
		rd(`SCC_ADDR_RDR, 8'h00);
		rd(32'hFFFFFE8E, 8'h00);
		chk({14'h0, sck_oe, sck_port_sel}, 16'h1);
		wr(`SCC_ADDR_CMR, 8'hFF);
		rd(`SCC_ADDR_CMR, 8'h0D);
		wr(`SCC_ADDR_CMR, 8'h01);
		for (k = 0; k < 8; k++)
			if (k[2] || !k[1])
			begin
				wr(`SCC_ADDR_SMR, {k[2], 7'h28});
				wr(`SCC_ADDR_SCR, {6'h00, k[1:0]});
				repeat (2) @(posedge mclk);
				chk({14'h0, sck_oe, sck_port_sel}, (k[0] | k[2]) ? 16'h2 : 16'h1);
				if (k[2] && !k[0])
					chk({15'h0, sck_o}, {15'h0, k[1]});
			end
		for (n = 0; n < 4; n++)
		begin
			d = 8'($random(seed)) & 8'h03;
			wr(`SCC_ADDR_SCR, 8'h00);
			wr(`SCC_ADDR_SMR, 8'h28 | 8'(n));
			wr(`SCC_ADDR_BRR, d);
			wr(`SCC_ADDR_SCR, 8'h01);
			till(0, 0);
			till(0, 1);
			till(0, 0);
			h = cyc;
			till(0, 1);
			chk(16'(h + cyc), 16'((d + 1) << (2 * n + 1)));
			chk(16'(h), 16'((d + 1) << (2 * n)));
		end
		for (k = 0; k < 2; k++)
		begin
			d = k ? 8'h3F : 8'h3B;
			wr(`SCC_ADDR_SCR, 8'h00);
			wr(`SCC_ADDR_SMR, k ? 8'hB8 : 8'h28);
			wr(`SCC_ADDR_BRR, 8'h00);
			wr(`SCC_ADDR_CMR, k ? 8'h0D : 8'h01);
			wr(`SCC_ADDR_SCR, 8'h20);
			wr(`SCC_ADDR_TDR, d);
			wr(`SCC_ADDR_SSR, 8'h7F);
			till(1, 1);
			for (i = 0; i < 10; i++)
			begin
				repeat (i ? 744 : 372) @(posedge mclk);
				bv[i] = line;
			end
			chk({6'h0, bv}, {6'h0, expl(d, k[0])});
			repeat (k ? 1016 : 2132) @(posedge mclk);
			rd(`SCC_ADDR_SSR, 8'h80);
			repeat (200) @(posedge mclk);
			rd(`SCC_ADDR_SSR, 8'h84);
		end
		wr(`SCC_ADDR_SCR, 8'h00);
		wr(`SCC_ADDR_SMR, 8'h28);
		wr(`SCC_ADDR_CMR, 8'h01);
		wr(`SCC_ADDR_SCR, 8'h10);
		d = 8'($random(seed));
		for (k = 1; k >= 0; k--)
		begin
			i_card.send(expl(d, 1'b0) ^ {k[0], 9'h000});
			repeat (100) @(posedge mclk);
			rd(`SCC_ADDR_SSR, k ? 8'h8C : 8'hC4);
			wr(`SCC_ADDR_SSR, 8'hF7);
		end
		rd(`SCC_ADDR_RDR, d);
		repeat (3) @(posedge mclk);
		test_done;
	end
endmodule
`default_nettype wire
